// [inc/proxy_regs_pkg.sv]
// constants, carriers and state types shared by the proxy control register bank
//
// Overview of operation
// - proxy logic stays in reset while the proxy enable bit is zero.
// - code-loaded is set by software, or by hardware after the first code packet.
// - hardware sets ready-for-code once either code load flag is set.
// - with auto-disable set, proxying stops after the link-down period elapses.
// - link-down period comes from bits 13:8, counted in whole seconds.
// - read-only 16-bit checksum over the code packet, reset to zero.
// - flexible filters 0-7 are routed to the proxy when their routing bit is set and the proxy enable bit is set.
// - a flexible filter 0-7 match sets its sticky status bit in bits 15:8.
// - writing one clears a match status bit; writing zero keeps it.
// - status bit 8 reports filter 0, up to bit 15 for filter 7.
// - bits 7:0 enable flexible filters 8-15; bits 15:8 are reserved.
// - three 32-bit IPv4 addresses are stored and matched for wake-up.
// - an IPv4 address is compared only while its valid bit 1-3 is set.
package proxy_regs_pkg;

  // ----------------------------------------------------------------
  // register numbers on the management page
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_VALID_OFS = 8'h40;
  localparam logic [7:0] PROXY_CONTROL_OFS = 8'h46;
  localparam logic [7:0] PROXY_CHECKSUM_OFS = 8'h47;
  localparam logic [7:0] PROXY_CONTROL2_OFS = 8'h48;
  localparam logic [7:0] FLEX_ROUTING_OFS = 8'h4B;
  localparam logic [7:0] UPPER_FLEX_OFS = 8'h4C;
  localparam logic [7:0] IPV4_BASE_OFS = 8'h52;
  localparam logic [7:0] IPV4_LAST_OFS = 8'h57;

  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int PROXY_EN_BIT = 0;
  localparam int CODE_LOADED_BIT = 1;
  localparam int CODE_VIA_MGMT_BIT = 2;
  localparam int NEXT_PKT_CODE_BIT = 3;
  localparam int AUTO_DISABLE_BIT = 4;
  localparam int ARP_EN_BIT = 5;
  localparam int ND_EN_BIT = 6;
  localparam int PERIOD_LSB = 8;
  localparam int READY_BIT = 15;
  localparam int MLD_EN_BIT = 14;
  localparam int ADDR_VALID_LSB = 1;
  localparam logic [15:0] CONTROL_WMASK = 16'hBF7F;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CHECKSUM_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // timing: one second of link-down time in clock cycles
  // ----------------------------------------------------------------
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } code_stream_s;

  typedef struct packed {
    logic active;
    logic done;
    logic [15:0] sum;
  } cksum_state_s;

  typedef struct packed {
    logic [31:0] cyc;
    logic [5:0] sec;
    logic expired;
  } timer_state_s;

  typedef struct packed {
    logic [15:0] control;
    logic mld_en;
    logic [7:0] route;
    logic [7:0] match;
    logic [7:0] upper_en;
    logic [2:0] addr_valid;
    logic [2:0][31:0] ipv4;
    logic [15:0] rdata;
    logic [7:0] flex_to_proxy;
    logic ipv4_hit;
  } regs_state_s;

endpackage

// [rtl/code_checksum.sv]
// checksum over the microcode packet streamed towards the transmit FIFO
`timescale 1ns/1ns
module code_checksum
  import proxy_regs_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic armed_in,
  input code_stream_s stream_in,
  output logic [15:0] checksum_out,
  output logic done_out
);

  cksum_state_s r_reg;
  cksum_state_s r_next;

  // only a frame that starts while armed is summed; later frames are ignored
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (stream_in.valid)
    begin
      if (stream_in.sof && armed_in)
      begin
        r_next.sum = {8'h00, stream_in.data};
        r_next.active = !stream_in.eof;
        r_next.done = stream_in.eof;
      end
      else if (r_reg.active)
      begin
        r_next.sum = r_reg.sum + {8'h00, stream_in.data};
        if (stream_in.eof)
        begin
          r_next.active = 1'b0;
          r_next.done = 1'b1;
        end
      end
    end
  end

  // checksum clears only on reset, then holds the last code packet
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      r_reg <= '{active: 1'b0, done: 1'b0, sum: CHECKSUM_RESET};
    else
      r_reg <= r_next;
  end

  assign checksum_out = r_reg.sum;
  assign done_out = r_reg.done;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_sum_starts;
    stream_in.valid && stream_in.sof && armed_in |=> checksum_out == {8'h00, $past(stream_in.data)};
  endproperty
  a_sum_starts: assert property (p_sum_starts) else $error("checksum not restarted at frame");

endmodule

// [rtl/link_down_timer.sv]
// counts whole seconds of link-down time against the programmed period
`timescale 1ns/1ns
module link_down_timer
  import proxy_regs_pkg::*;
#(
  parameter int unsigned ONE_SECOND = SECOND_CYCLES
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [5:0] period_in,
  output logic expired_out
);

  timer_state_s r_reg;
  timer_state_s r_next;

  // any link-up or disable restarts the count from zero
  always_comb
  begin
    r_next = r_reg;
    r_next.expired = 1'b0;
    if (!run_in)
    begin
      r_next.cyc = 32'h0000_0000;
      r_next.sec = 6'h00;
    end
    else if (r_reg.sec >= period_in)
      r_next.expired = 1'b1;
    else if (r_reg.cyc == 32'(ONE_SECOND - 1))
    begin
      r_next.cyc = 32'h0000_0000;
      r_next.sec = 6'(r_reg.sec + 6'h01);
    end
    else
      r_next.cyc = r_reg.cyc + 32'h0000_0001;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign expired_out = r_reg.expired;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_idle_quiet;
    !run_in |=> !expired_out && r_reg.sec == 6'h00;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("timer active while idle");

endmodule

// [rtl/proxy_control_regs.sv]
// proxy offload and extended flexible filter control register bank
`timescale 1ns/1ns
module proxy_control_regs
  import proxy_regs_pkg::*;
#(
  parameter int unsigned ONE_SECOND = SECOND_CYCLES
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input reg_req_s req_in,
  output logic [15:0] reg_rdata_out,
  input wire logic link_up_in,
  input code_stream_s code_in,
  input wire logic [7:0] flex_match_in,
  input wire logic pkt_ipv4_valid_in,
  input wire logic [31:0] pkt_ipv4_in,
  output logic proxy_reset_n_out,
  output logic arp_proxy_en_out,
  output logic nd_proxy_en_out,
  output logic mld_proxy_en_out,
  output logic code_via_mgmt_out,
  output logic [7:0] flex_to_proxy_out,
  output logic [7:0] upper_flex_en_out,
  output logic ipv4_hit_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // sticky flags: a new event wins over a write-one clear in the same cycle
  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] clr,
                                        input logic [7:0] set);
    sticky = (cur & ~clr) | set;
  endfunction

  // write one 16-bit half of a 32-bit address entry
  function automatic logic [31:0] put_half(input logic [31:0] cur, input logic hi,
                                           input logic [15:0] data);
    put_half = hi ? {data, cur[15:0]} : {cur[31:16], data};
  endfunction

  regs_state_s r_reg;
  regs_state_s r_next;
  logic [15:0] checksum;
  logic code_done;
  logic expired;
  logic armed;
  logic [7:0] ip_ofs;
  logic [1:0] ip_idx;
  logic [2:0] ip_eq;

  // ----------------------------------------------------------------
  // code packet checksum and link-down timer
  // ----------------------------------------------------------------

  // only the first packet after next-packet-is-code counts as code
  assign armed = r_reg.control[NEXT_PKT_CODE_BIT] && !r_reg.control[CODE_LOADED_BIT];

  code_checksum u_checksum (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .armed_in(armed),
    .stream_in(code_in),
    .checksum_out(checksum),
    .done_out(code_done)
  );

  link_down_timer #(.ONE_SECOND(ONE_SECOND)) u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(r_reg.control[AUTO_DISABLE_BIT] && r_reg.control[PROXY_EN_BIT] && !link_up_in),
    .period_in(r_reg.control[PERIOD_LSB +: 6]),
    .expired_out(expired)
  );

  // ----------------------------------------------------------------
  // address table decode and compare
  // ----------------------------------------------------------------

  // each entry spans two registers, low half at the even number
  assign ip_ofs = req_in.addr - IPV4_BASE_OFS;
  assign ip_idx = ip_ofs[2:1];

  // a stored address takes part only while its valid bit is set
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      ip_eq[i] = r_reg.addr_valid[i] && (r_reg.ipv4[i] == pkt_ipv4_in);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    if (req_in.wr)
    begin
      case (req_in.addr)
        PROXY_CONTROL_OFS:
          r_next.control = req_in.wdata & CONTROL_WMASK;
        PROXY_CONTROL2_OFS:
          r_next.mld_en = req_in.wdata[MLD_EN_BIT];
        FLEX_ROUTING_OFS:
          r_next.route = req_in.wdata[7:0];
        UPPER_FLEX_OFS:
          r_next.upper_en = req_in.wdata[7:0];
        ADDR_VALID_OFS:
          r_next.addr_valid = req_in.wdata[ADDR_VALID_LSB +: 3];
        default:
        begin
          if (req_in.addr >= IPV4_BASE_OFS && req_in.addr <= IPV4_LAST_OFS)
            r_next.ipv4[ip_idx] = put_half(r_reg.ipv4[ip_idx], ip_ofs[0], req_in.wdata);
        end
      endcase
    end

    // match status: write-one clears, new matches set, set wins
    r_next.match = sticky(r_reg.match,
                          (req_in.wr && req_in.addr == FLEX_ROUTING_OFS) ?
                          req_in.wdata[15:8] : 8'h00,
                          flex_match_in);

    // hardware sets win over the software value written in the same cycle
    if (r_reg.control[CODE_VIA_MGMT_BIT] || r_reg.control[NEXT_PKT_CODE_BIT])
      r_next.control[READY_BIT] = 1'b1;
    if (code_done)
      r_next.control[CODE_LOADED_BIT] = 1'b1;
    if (expired)
      r_next.control[PROXY_EN_BIT] = 1'b0;

    // routed matches reach the proxy only while it runs
    r_next.flex_to_proxy = r_reg.control[PROXY_EN_BIT] ? (flex_match_in & r_reg.route) : 8'h00;
    r_next.ipv4_hit = pkt_ipv4_valid_in && (|ip_eq);

    // read data is captured on the strobe and holds until the next read
    if (req_in.rd)
    begin
      case (req_in.addr)
        PROXY_CONTROL_OFS:
          r_next.rdata = r_reg.control;
        PROXY_CHECKSUM_OFS:
          r_next.rdata = checksum;
        PROXY_CONTROL2_OFS:
          r_next.rdata = {1'b0, r_reg.mld_en, 14'h0000};
        FLEX_ROUTING_OFS:
          r_next.rdata = {r_reg.match, r_reg.route};
        UPPER_FLEX_OFS:
          r_next.rdata = {8'h00, r_reg.upper_en};
        ADDR_VALID_OFS:
          r_next.rdata = {12'h000, r_reg.addr_valid, 1'b0};
        default:
        begin
          if (req_in.addr >= IPV4_BASE_OFS && req_in.addr <= IPV4_LAST_OFS)
            r_next.rdata = ip_ofs[0] ? r_reg.ipv4[ip_idx][31:16] : r_reg.ipv4[ip_idx][15:0];
          else
            r_next.rdata = 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // address entries also clear here; zero is one legal undefined value
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      r_reg <= '0;
      r_reg.control <= CONTROL_RESET;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out = r_reg.rdata;
  assign proxy_reset_n_out = r_reg.control[PROXY_EN_BIT];
  assign arp_proxy_en_out = r_reg.control[ARP_EN_BIT];
  assign nd_proxy_en_out = r_reg.control[ND_EN_BIT];
  assign mld_proxy_en_out = r_reg.mld_en;
  assign code_via_mgmt_out = r_reg.control[CODE_VIA_MGMT_BIT];
  assign flex_to_proxy_out = r_reg.flex_to_proxy;
  assign upper_flex_en_out = r_reg.upper_en;
  assign ipv4_hit_out = r_reg.ipv4_hit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_proxy_held;
    req_in.wr && req_in.addr == PROXY_CONTROL_OFS && !req_in.wdata[PROXY_EN_BIT]
      |=> !proxy_reset_n_out;
  endproperty
  a_proxy_held: assert property (p_proxy_held) else $error("proxy left out of reset");

  property p_ready;
    req_in.wr && req_in.addr == PROXY_CONTROL_OFS && (|req_in.wdata[3:2])
      |=> ##1 r_reg.control[READY_BIT];
  endproperty
  a_ready: assert property (p_ready) else $error("ready-for-code not set");

  property p_code_loaded;
    code_done |=> r_reg.control[CODE_LOADED_BIT];
  endproperty
  a_code_loaded: assert property (p_code_loaded) else $error("code-loaded not set");

  property p_auto_off;
    expired |=> !proxy_reset_n_out;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("proxy not stopped");

  property p_match_set;
    |flex_match_in |=> (r_reg.match & $past(flex_match_in)) == $past(flex_match_in);
  endproperty
  a_match_set: assert property (p_match_set) else $error("match flag lost");

  property p_match_clear;
    req_in.wr && req_in.addr == FLEX_ROUTING_OFS && req_in.wdata[15:8] == 8'hFF
      && flex_match_in == 8'h00 |=> r_reg.match == 8'h00;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match not cleared");

  property p_match_keep;
    req_in.wr && req_in.addr == FLEX_ROUTING_OFS && req_in.wdata[15:8] == 8'h00
      |=> r_reg.match == ($past(r_reg.match) | $past(flex_match_in));
  endproperty
  a_match_keep: assert property (p_match_keep) else $error("zero write changed match");

  property p_routing;
    proxy_reset_n_out |=> flex_to_proxy_out == ($past(flex_match_in) & $past(r_reg.route));
  endproperty
  a_routing: assert property (p_routing) else $error("routed match wrong");

  property p_upper_rsvd;
    req_in.rd && req_in.addr == UPPER_FLEX_OFS |=> reg_rdata_out[15:8] == 8'h00;
  endproperty
  a_upper_rsvd: assert property (p_upper_rsvd) else $error("reserved bits nonzero");

  property p_ip_valid;
    pkt_ipv4_valid_in && r_reg.addr_valid == 3'h0 |=> !ipv4_hit_out;
  endproperty
  a_ip_valid: assert property (p_ip_valid) else $error("hit on invalid address");

  // routed matches must never leak to a proxy that is held in reset
  property p_route_idle;
    !proxy_reset_n_out |=> flex_to_proxy_out == 8'h00;
  endproperty
  a_route_idle: assert property (p_route_idle) else $error("match routed while proxy off");

  // only a software write can take the proxy out of reset
  property p_enable_by_write;
    !proxy_reset_n_out && !(req_in.wr && req_in.addr == PROXY_CONTROL_OFS)
      |=> !proxy_reset_n_out;
  endproperty
  a_enable_by_write: assert property (p_enable_by_write) else $error("proxy enabled unasked");

  property p_ready_hold;
    r_reg.control[CODE_VIA_MGMT_BIT] || r_reg.control[NEXT_PKT_CODE_BIT]
      |=> r_reg.control[READY_BIT];
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready-for-code dropped");

  property p_sw_loaded;
    req_in.wr && req_in.addr == PROXY_CONTROL_OFS && req_in.wdata[CODE_LOADED_BIT]
      |=> r_reg.control[CODE_LOADED_BIT];
  endproperty
  a_sw_loaded: assert property (p_sw_loaded) else $error("software code-loaded lost");

  property p_period_field;
    req_in.wr && req_in.addr == PROXY_CONTROL_OFS
      |=> r_reg.control[PERIOD_LSB +: 6] == $past(req_in.wdata[PERIOD_LSB +: 6]);
  endproperty
  a_period_field: assert property (p_period_field) else $error("period field not stored");

  property p_checksum_read;
    req_in.rd && req_in.addr == PROXY_CHECKSUM_OFS |=> reg_rdata_out == $past(checksum);
  endproperty
  a_checksum_read: assert property (p_checksum_read) else $error("checksum read wrong");

  // a write to the read-only checksum must not disturb it
  property p_checksum_ro;
    req_in.wr && req_in.addr == PROXY_CHECKSUM_OFS && !code_in.valid |=> $stable(checksum);
  endproperty
  a_checksum_ro: assert property (p_checksum_ro) else $error("checksum changed by write");

  property p_route_write;
    req_in.wr && req_in.addr == FLEX_ROUTING_OFS |=> r_reg.route == $past(req_in.wdata[7:0]);
  endproperty
  a_route_write: assert property (p_route_write) else $error("routing bits not stored");

  property p_status_read;
    req_in.rd && req_in.addr == FLEX_ROUTING_OFS |=> reg_rdata_out[15:8] == $past(r_reg.match);
  endproperty
  a_status_read: assert property (p_status_read) else $error("match status misplaced");

  property p_upper_write;
    req_in.wr && req_in.addr == UPPER_FLEX_OFS
      |=> upper_flex_en_out == $past(req_in.wdata[7:0]);
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("upper enables not stored");

  // the last entry proves the address compare reaches the top of the table
  property p_ip_match;
    pkt_ipv4_valid_in && r_reg.addr_valid[2] && r_reg.ipv4[2] == pkt_ipv4_in
      |=> ipv4_hit_out;
  endproperty
  a_ip_match: assert property (p_ip_match) else $error("valid address missed");

  property p_control_rsvd;
    req_in.rd && req_in.addr == PROXY_CONTROL_OFS |=> !reg_rdata_out[7] && !reg_rdata_out[14];
  endproperty
  a_control_rsvd: assert property (p_control_rsvd) else $error("control reserved nonzero");

  property p_control2_rsvd;
    req_in.rd && req_in.addr == PROXY_CONTROL2_OFS
      |=> reg_rdata_out[13:0] == 14'h0000 && !reg_rdata_out[15];
  endproperty
  a_control2_rsvd: assert property (p_control2_rsvd) else $error("control2 reserved nonzero");

  property p_valid_rsvd;
    req_in.rd && req_in.addr == ADDR_VALID_OFS
      |=> reg_rdata_out[15:4] == 12'h000 && !reg_rdata_out[0];
  endproperty
  a_valid_rsvd: assert property (p_valid_rsvd) else $error("valid reserved nonzero");

endmodule

// [tb/mac_stub.sv]
// far-side model of the MAC: code frames, filter match events, packet addresses
`timescale 1ns/1ns
module mac_stub
  import proxy_regs_pkg::*;
(
  input wire logic clk_in,
  output code_stream_s code_out,
  output logic [7:0] flex_out,
  output logic ip_valid_out,
  output logic [31:0] ip_out
);
  initial
  begin
    code_out = '0;
    flex_out = 8'h00;
    ip_valid_out = 1'b0;
    ip_out = 32'h00000000;
  end

  // ----------------------------------------------------------------
  // three-byte code frame, sof on the first byte and eof on the last
  // ----------------------------------------------------------------
  // idle data is the inverse of the last byte so a held copy never passes
  task automatic send_code(input logic [7:0] b [3]);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_in);
      #1;
      code_out = '{valid: 1'b1, sof: (i == 0), eof: (i == 2), data: b[i]};
    end
    @(posedge clk_in);
    #1;
    code_out = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~b[2]};
  endtask

  // one-cycle filter match pulse
  task automatic pulse_flex(input logic [7:0] m);
    @(posedge clk_in);
    #1;
    flex_out = m;
    @(posedge clk_in);
    #1;
    flex_out = 8'h00;
  endtask

  // one packet address, invalid afterwards and inverted so it cannot linger
  task automatic send_ip(input logic [31:0] a);
    @(posedge clk_in);
    #1;
    ip_valid_out = 1'b1;
    ip_out = a;
    @(posedge clk_in);
    #1;
    ip_valid_out = 1'b0;
    ip_out = ~a;
  endtask
endmodule

// [tb/network_proxy_control_regs_test.sv]
// self-checking bench for the proxy control register bank
`timescale 1ns/1ns
module network_proxy_control_regs_test
  import proxy_regs_pkg::*;
;
  // short second keeps the link-down test to a few dozen cycles
  localparam int unsigned SEC = 10;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  reg_req_s req = '0;
  logic link_up = 1'b1;
  logic [15:0] rdata;
  code_stream_s code;
  logic [7:0] flex;
  logic ipv;
  logic [31:0] ip;
  logic prst_n, arp_en, nd_en, mld_en, via_mgmt, hit;
  logic [7:0] to_proxy, upper_en;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;

  proxy_control_regs #(.ONE_SECOND(SEC)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .req_in(req), .reg_rdata_out(rdata),
    .link_up_in(link_up), .code_in(code), .flex_match_in(flex),
    .pkt_ipv4_valid_in(ipv), .pkt_ipv4_in(ip), .proxy_reset_n_out(prst_n),
    .arp_proxy_en_out(arp_en), .nd_proxy_en_out(nd_en), .mld_proxy_en_out(mld_en),
    .code_via_mgmt_out(via_mgmt), .flex_to_proxy_out(to_proxy),
    .upper_flex_en_out(upper_en), .ipv4_hit_out(hit)
  );

  mac_stub mac (.clk_in(clk_in), .code_out(code), .flex_out(flex),
    .ip_valid_out(ipv), .ip_out(ip));

  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch and still ends in the report
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apply_reset();
    resetn_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
  endtask

  // one write strobe; the leading edge keeps two drives out of one time step
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    #1;
    req = '0;
  endtask

  // read data is registered at the strobe edge, so it is settled just after it
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    #1;
    req = '0;
    check($sformatf("reg %h", a), {16'h0000, exp}, {16'h0000, rdata});
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    // proxy control comes last so the enable is the final configuration write
    static logic [7:0] ra [14] = '{8'h40, 8'h47, 8'h48, 8'h4B, 8'h4C, 8'h52, 8'h53, 8'h54,
                                   8'h55, 8'h56, 8'h57, 8'h41, 8'h4A, 8'h46};
    static logic [15:0] wv [14] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFFFF,
                                    16'h5678, 16'h1234, 16'hBEEF, 16'hDEAD, 16'h0102,
                                    16'h0A0B, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    static logic [15:0] ev [14] = '{16'h000E, 16'h0000, 16'h4000, 16'h00FF, 16'h00FF,
                                    16'h5678, 16'h1234, 16'hBEEF, 16'hDEAD, 16'h0102,
                                    16'h0A0B, 16'h0000, 16'h0000, 16'hBF7F};
    apply_reset();
    for (int i = 0; i < 14; i++)
      reg_rd(ra[i], 16'h0000);
    $display("test reset_values done");

    // link stays up so auto-disable cannot clear the enable written here
    for (int i = 0; i < 14; i++)
      reg_wr(ra[i], wv[i]);
    for (int i = 0; i < 14; i++)
      reg_rd(ra[i], ev[i]);
    check("proxy_reset_n", 1, prst_n);
    check("arp_nd_mld_via", 4'hF, {arp_en, nd_en, mld_en, via_mgmt});
    check("upper_en", 8'hFF, upper_en);
    $display("test access_masks done");

    apply_reset();
    reg_wr(8'h46, 16'h0008);
    reg_rd(8'h46, 16'h8008);
    mac.send_code('{8'h12, 8'h34, 8'hFF});
    repeat (3) @(posedge clk_in);
    #1;
    reg_rd(8'h47, 16'h0145);
    reg_rd(8'h46, 16'h800A);
    // code already loaded, so this frame must leave the sum alone
    mac.send_code('{8'h01, 8'h01, 8'h01});
    repeat (3) @(posedge clk_in);
    #1;
    reg_rd(8'h47, 16'h0145);
    reg_wr(8'h46, 16'h0004);
    check("via_mgmt", 1, via_mgmt);
    reg_rd(8'h46, 16'h8004);
    reg_wr(8'h46, 16'h0006);
    reg_rd(8'h46, 16'h8006);
    $display("test code_load done");

    apply_reset();
    reg_wr(8'h4B, 16'h0055);
    mac.pulse_flex(8'h01);
    check("to_proxy_off", 8'h00, to_proxy);
    check("proxy_reset_n", 0, prst_n);
    reg_wr(8'h46, 16'h0001);
    for (int i = 0; i < 8; i++)
    begin
      mac.pulse_flex(8'h01 << i);
      check("to_proxy", 8'h55 & (8'h01 << i), to_proxy);
    end
    reg_rd(8'h4B, 16'hFF55);
    reg_wr(8'h4B, 16'h0F55);
    reg_rd(8'h4B, 16'hF055);
    reg_wr(8'h4B, 16'hFF55);
    reg_rd(8'h4B, 16'h0055);
    $display("test flex_routing done");

    apply_reset();
    for (int n = 0; n < 3; n++)
    begin
      reg_wr(8'h52 + 8'(2 * n), 16'h0001 + 16'(n));
      reg_wr(8'h53 + 8'(2 * n), 16'hC0A8);
    end
    for (int n = 0; n < 3; n++)
    begin
      reg_wr(8'h40, 16'h0000);
      mac.send_ip(32'hC0A80001 + 32'(n));
      check("hit_invalid", 0, hit);
      reg_wr(8'h40, 16'h0002 << n);
      mac.send_ip(32'hC0A80001 + 32'(n));
      check("hit_valid", 1, hit);
      mac.send_ip(32'hC0A80001 + 32'((n + 1) % 3));
      check("hit_other", 0, hit);
    end
    $display("test ipv4_match done");

    apply_reset();
    reg_wr(8'h46, 16'h0211);
    link_up = 1'b0;
    // two seconds of link-down, then two edges through timer and control bit
    repeat (2 * SEC + 1) @(posedge clk_in);
    #1;
    check("proxy_before_period", 1, prst_n);
    repeat (1) @(posedge clk_in);
    #1;
    check("proxy_after_period", 0, prst_n);
    reg_rd(8'h46, 16'h0210);
    $display("test auto_disable done");
    finish_test();
  end
endmodule
